// ==== scp_pkg.sv ====
// Purpose: constants for the system control ports and nmi logic
// Assumes: 10 MHz sys_clk, 8-bit i/o data, 16-bit port addresses
// Notes:   offsets, fields, reset values and timing counts live here
`default_nettype none
package scp_pkg;

  // ****************************************
  // port addresses
  // ****************************************
  localparam logic [15:0] MISC_STATUS_CONTROL_B_OFS = 16'h0061;
  localparam logic [15:0] MISC_CONTROL_A_OFS        = 16'h0092;
  localparam logic [15:0] ARB_REG_OFS               = 16'h0090;

  // ****************************************
  // port b fields
  // ****************************************
  localparam int B_TIMER0_CLR_BIT = 7;
  localparam int B_PARITY_BIT     = 7;
  localparam int B_CHANNEL_BIT    = 6;
  localparam int B_T2OUT_BIT      = 5;
  localparam int B_REFRESH_BIT    = 4;
  localparam int B_CHAN_DIS_BIT   = 3;
  localparam int B_PAR_DIS_BIT    = 2;
  localparam int B_SPK_EN_BIT     = 1;
  localparam int B_T2GATE_BIT     = 0;
  localparam logic B_CHAN_DIS_RST = 1'b1;
  localparam logic B_PAR_DIS_RST  = 1'b1;
  localparam logic B_SPK_EN_RST   = 1'b0;
  localparam logic B_T2GATE_RST   = 1'b0;

  // ****************************************
  // port a fields
  // ****************************************
  localparam int A_LIGHT1_BIT   = 7;
  localparam int A_LIGHT0_BIT   = 6;
  localparam int A_WDOG_BIT     = 4;
  localparam int A_LOCK_BIT     = 3;
  localparam int A_GATE20_BIT   = 1;
  localparam int A_HOTRST_BIT   = 0;
  localparam logic [1:0] A_LIGHT_RST = 2'h0;
  localparam logic A_LOCK_RST   = 1'b0;
  localparam logic A_GATE20_RST = 1'b0;
  localparam logic A_HOTRST_RST = 1'b0;

  // ****************************************
  // arbitration register and nmi mask
  // ****************************************
  localparam int ARB_NMI_HOLD_BIT = 6;
  localparam logic NMI_MASK_RST   = 1'b1;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS    = 100;
  localparam int RST_DELAY_NS     = 6720;
  localparam int RST_PULSE_MIN_NS = 100;
  localparam int RST_TOTAL_NS     = 13400;
  // least delay rounds up
  localparam int RST_DELAY_CYC    = (RST_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // pulse 100..125 ns: one 100 ns cycle
  localparam int RST_PULSE_CYC    = (RST_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_TOTAL_CYC    = RST_TOTAL_NS / CLK_PERIOD_NS;
  localparam int RST_CNT_W        = 8;

  typedef enum logic [1:0] {HR_IDLE, HR_WAIT, HR_PULSE, HR_HOLD} scp_hot_t;

endpackage

`default_nettype wire

// ==== scp_hot_reset.sv ====
// Purpose: alternate processor reset sequencer
// Assumes: start is a one-cycle pulse on a 0 to 1 write of the reset bit
// Notes:   delay, pulse, then hold until the whole sequence time is spent
`timescale 1ns/1ps
`default_nettype none

module scp_hot_reset (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // control
  input  wire logic start,
  output logic      cpuResetPulse,
  output logic      busy
);

  scp_pkg::scp_hot_t                state_r;
  scp_pkg::scp_hot_t                state_nxt;
  logic [scp_pkg::RST_CNT_W-1:0]    count_r;
  logic [scp_pkg::RST_CNT_W-1:0]    count_nxt;

  localparam logic [scp_pkg::RST_CNT_W-1:0] DELAY_LAST =
    scp_pkg::RST_CNT_W'(scp_pkg::RST_DELAY_CYC - 1);
  localparam logic [scp_pkg::RST_CNT_W-1:0] PULSE_LAST =
    scp_pkg::RST_CNT_W'(scp_pkg::RST_DELAY_CYC + scp_pkg::RST_PULSE_CYC - 1);
  localparam logic [scp_pkg::RST_CNT_W-1:0] TOTAL_LAST =
    scp_pkg::RST_CNT_W'(scp_pkg::RST_TOTAL_CYC - 1);

  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r + 8'h01;
    unique case (state_r)
      scp_pkg::HR_IDLE: begin
        count_nxt = 8'h00;
        if (start) begin
          state_nxt = scp_pkg::HR_WAIT;
        end
      end
      scp_pkg::HR_WAIT: begin
        if (count_r == DELAY_LAST) begin
          state_nxt = scp_pkg::HR_PULSE;
        end
      end
      scp_pkg::HR_PULSE: begin
        if (count_r == PULSE_LAST) begin
          state_nxt = scp_pkg::HR_HOLD;
        end
      end
      scp_pkg::HR_HOLD: begin
        if (count_r == TOTAL_LAST) begin
          state_nxt = scp_pkg::HR_IDLE;
          count_nxt = 8'h00;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= scp_pkg::HR_IDLE;
      count_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
    end
  end

  assign cpuResetPulse = (state_r == scp_pkg::HR_PULSE);
  assign busy          = (state_r != scp_pkg::HR_IDLE);

endmodule // scp_hot_reset

`default_nettype wire

// ==== scp_system_control.sv ====
// Purpose: system control ports b and a, nmi generation and masking
// Assumes: single-cycle i/o strobes from the processor side, 10 MHz clock
// Notes:   timer, real-time memory, arbiter and watchdog are outside
// Functional notes
// - raise nmi on parity error, channel check, channel or watchdog time-out.
// - pending nmi halts arbitration until software clears arbitration bit 6.
// - system reset clears any pending nmi.
// - parity and channel check nmi requests are gated by the nmi mask.
// - watchdog and channel time-out bypass the nmi mask.
// - nmi mask is 1 after power-on.
// - writing 1 to port b bit 7 clears the timer 0 latch.
// - port b bits 7 and 6 read parity and channel check flags.
// - port b bit 5 reads timer 2 output level.
// - port b bit 4 toggles per refresh request.
// - port b bits 3, 2 active-low check enables, set by power-on.
// - port b bit 1 speaker enable, cleared at power-on; bit 0 timer 2 gate.
// - activity light on when port a bit 7 or 6 set; both reset 0.
// - port a bit 4 reads watchdog time-out status.
// - port a bit 3 locks password area until power removal.
// - port a bit 1 low blocks address line twenty; system reset clears it.
// - port a bit 0 cleared by system reset or software write of 0.
// - 0 to 1 write of port a bit 0 pulses alternate reset high.
// - reset starts at least 6.72 us after write; whole sequence 13.4 us.
// - port a bit 0 stays set through the triggered reset.
`timescale 1ns/1ps
`default_nettype none

module scp_system_control (
  // clock and resets
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        powerOnRst,
  // processor i/o access
  input  wire logic [15:0] ioAddr,
  input  wire logic [7:0]  ioWrData,
  input  wire logic        ioWr,
  input  wire logic        ioRd,
  output logic      [7:0]  ioRdData,
  output logic             ioRdValid,
  // error sources
  input  wire logic        parityErr,
  input  wire logic        channelCheck,
  input  wire logic        channelTimeout,
  input  wire logic        watchdogTimeout,
  input  wire logic        watchdogStatus,
  // nmi mask from real_time_memory address register
  input  wire logic        nmiMaskWr,
  input  wire logic        nmiMaskData,
  // timer and refresh
  input  wire logic        timer2Out,
  input  wire logic        refreshReq,
  // outputs
  output logic             nmi,
  output logic             arbHalt,
  output logic             timer0InterruptRequestClr,
  output logic             speakerDataEn,
  output logic             timer2Gate,
  output logic             activityLight,
  output logic             passwordLock,
  output logic             addressLineTwentyEn,
  output logic             cpuAltReset
);

  // ****************************************
  // decode
  // ****************************************
  wire logic selB    = (ioAddr == scp_pkg::MISC_STATUS_CONTROL_B_OFS);
  wire logic selA    = (ioAddr == scp_pkg::MISC_CONTROL_A_OFS);
  wire logic selArb  = (ioAddr == scp_pkg::ARB_REG_OFS);
  wire logic wrB     = ioWr & selB;
  wire logic wrA     = ioWr & selA;
  wire logic arbClr  = ioWr & selArb & ~ioWrData[scp_pkg::ARB_NMI_HOLD_BIT];

  // ****************************************
  // registers
  // ****************************************
  logic       nmiMask_r;
  logic       parityFlag_r;
  logic       channelFlag_r;
  logic       nmiPend_r;
  logic       refreshTog_r;
  logic       chanDis_r;
  logic       parDis_r;
  logic       spkEn_r;
  logic       t2Gate_r;
  logic [1:0] light_r;
  logic       lock_r;
  logic       gate20_r;
  logic       hotRst_r;
  logic       t0Clr_r;
  logic [7:0] rdData_r;
  logic       rdValid_r;
  logic       hotBusy;
  logic       hotPulse;

  // ****************************************
  // nmi sources
  // ****************************************
  // flags latch only while their active-low enables are 0
  wire logic parityEvt  = parityErr & ~parDis_r;
  wire logic channelEvt = channelCheck & ~chanDis_r;
  wire logic maskedReq  = (parityEvt | channelEvt) & ~nmiMask_r;
  wire logic nmiReq     = maskedReq | channelTimeout | watchdogTimeout;
  // a new request in the clearing cycle wins
  wire logic nmiPend_nxt = nmiReq | (nmiPend_r & ~arbClr);
  // setting the active-low enable to 1 also drops the flag, so software can acknowledge it
  wire logic parity_nxt  = parityEvt | (parityFlag_r & ~parDis_r);
  wire logic channel_nxt = channelEvt | (channelFlag_r & ~chanDis_r);

  // ****************************************
  // port a write effects
  // ****************************************
  wire logic hotStart = wrA & ioWrData[scp_pkg::A_HOTRST_BIT] & ~hotRst_r;
  // bit stays set while the sequence runs, a 0 write then is held off
  wire logic hotRst_nxt = wrA & ~hotBusy ? ioWrData[scp_pkg::A_HOTRST_BIT]
                                         : hotRst_r;

  // ****************************************
  // read mux
  // ****************************************
  wire logic [7:0] rdB = {parityFlag_r, channelFlag_r, timer2Out, refreshTog_r,
                          chanDis_r, parDis_r, spkEn_r, t2Gate_r};
  wire logic [7:0] rdA = {light_r, 1'b0, watchdogStatus, lock_r, 1'b0,
                          gate20_r, hotRst_r};
  wire logic [7:0] rdMux = selB ? rdB : (selA ? rdA : 8'h00);

  // ****************************************
  // power-on state
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (powerOnRst) begin
      nmiMask_r <= scp_pkg::NMI_MASK_RST;
      chanDis_r <= scp_pkg::B_CHAN_DIS_RST;
      parDis_r  <= scp_pkg::B_PAR_DIS_RST;
      spkEn_r   <= scp_pkg::B_SPK_EN_RST;
      t2Gate_r  <= scp_pkg::B_T2GATE_RST;
      light_r   <= scp_pkg::A_LIGHT_RST;
      lock_r    <= scp_pkg::A_LOCK_RST;
    end else begin
      if (nmiMaskWr) begin
        nmiMask_r <= nmiMaskData;
      end
      if (wrB) begin
        chanDis_r <= ioWrData[scp_pkg::B_CHAN_DIS_BIT];
        parDis_r  <= ioWrData[scp_pkg::B_PAR_DIS_BIT];
        spkEn_r   <= ioWrData[scp_pkg::B_SPK_EN_BIT];
        t2Gate_r  <= ioWrData[scp_pkg::B_T2GATE_BIT];
      end
      if (wrA) begin
        light_r <= {ioWrData[scp_pkg::A_LIGHT1_BIT], ioWrData[scp_pkg::A_LIGHT0_BIT]};
        lock_r  <= lock_r | ioWrData[scp_pkg::A_LOCK_BIT];
      end
    end
  end

  // ****************************************
  // system reset state
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (rst | powerOnRst) begin
      nmiPend_r     <= 1'b0;
      parityFlag_r  <= 1'b0;
      channelFlag_r <= 1'b0;
      gate20_r      <= scp_pkg::A_GATE20_RST;
      hotRst_r      <= scp_pkg::A_HOTRST_RST;
      refreshTog_r  <= 1'b0;
      t0Clr_r       <= 1'b0;
    end else begin
      nmiPend_r     <= nmiPend_nxt;
      parityFlag_r  <= parity_nxt;
      channelFlag_r <= channel_nxt;
      hotRst_r      <= hotRst_nxt;
      refreshTog_r  <= refreshTog_r ^ refreshReq;
      t0Clr_r       <= wrB & ioWrData[scp_pkg::B_TIMER0_CLR_BIT];
      if (wrA) begin
        gate20_r <= ioWrData[scp_pkg::A_GATE20_BIT];
      end
    end
  end

  // ****************************************
  // read data
  // ****************************************
  // power-on also clears the read path, so no stale byte follows it
  always_ff @(posedge sys_clk) begin
    if (rst | powerOnRst) begin
      rdData_r  <= 8'h00;
      rdValid_r <= 1'b0;
    end else begin
      rdData_r  <= ioRd ? rdMux : 8'h00;
      rdValid_r <= ioRd & (selA | selB);
    end
  end

  // ****************************************
  // alternate reset
  // ****************************************
  scp_hot_reset u_hot (
    .sys_clk       (sys_clk),
    .rst           (rst | powerOnRst),
    .start         (hotStart),
    .cpuResetPulse (hotPulse),
    .busy          (hotBusy)
  );

  // ****************************************
  // outputs
  // ****************************************
  assign ioRdData                  = rdData_r;
  assign ioRdValid                 = rdValid_r;
  assign nmi                       = nmiPend_r;
  assign arbHalt                   = nmiPend_r;
  assign timer0InterruptRequestClr = t0Clr_r;
  assign speakerDataEn             = spkEn_r;
  assign timer2Gate                = t2Gate_r;
  assign activityLight             = |light_r;
  assign passwordLock              = lock_r;
  assign addressLineTwentyEn       = gate20_r;
  assign cpuAltReset               = hotPulse;

endmodule // scp_system_control

`default_nettype wire

// ==== scp_system_control_chk.sv ====
// Purpose: port checks for the system control ports and nmi logic
// Assumes: bound to scp_system_control, one clock domain
// Notes:   hot reset window counted from a write of 1 to port a bit 0 made outside a running sequence
`timescale 1ns/1ps
`default_nettype none
module scp_system_control_chk (
  // clock and resets
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        powerOnRst,
  // i/o access
  input wire logic [15:0] ioAddr,
  input wire logic [7:0]  ioWrData,
  input wire logic        ioWr,
  input wire logic        ioRd,
  input wire logic        ioRdValid,
  // error sources
  input wire logic        parityErr,
  input wire logic        channelCheck,
  input wire logic        channelTimeout,
  input wire logic        watchdogTimeout,
  // watched outputs
  input wire logic        nmi,
  input wire logic        arbHalt,
  input wire logic        timer0InterruptRequestClr,
  input wire logic        addressLineTwentyEn,
  input wire logic        passwordLock,
  input wire logic        cpuAltReset
);
  // ****************************************
  // helpers
  // ****************************************
  logic [7:0] sinceHot;
  wire logic wrA = ioWr && ioAddr == scp_pkg::MISC_CONTROL_A_OFS;
  wire logic wrB = ioWr && ioAddr == scp_pkg::MISC_STATUS_CONTROL_B_OFS;
  wire logic rdOk = ioRd && (ioAddr == 16'h0061 || ioAddr == 16'h0092);
  wire logic anyReq = parityErr || channelCheck || channelTimeout || watchdogTimeout;
  wire logic arbClr = ioWr && ioAddr == 16'h0090 && !ioWrData[6];
  // saturates so a stray pulse long after any write still fails
  always_ff @(posedge sys_clk) begin
    if (rst || powerOnRst) sinceHot <= 8'hFF;
    // a write of 1 while a sequence runs starts nothing, so it must not restart the count
    else if (wrA && ioWrData[0] && sinceHot > 8'h85) sinceHot <= 8'h00;
    else if (sinceHot != 8'hFF) sinceHot <= sinceHot + 8'h01;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst || powerOnRst);
  // ****************************************
  // assertions
  // ****************************************
  arb_follows_nmi_a: assert property (arbHalt == nmi)
    else $error("arbitration halt differs from nmi");
  unmasked_nmi_a: assert property ((watchdogTimeout || channelTimeout) |=> nmi)
    else $error("time-out did not raise nmi");
  nmi_release_a: assert property (arbClr && !anyReq |=> !nmi)
    else $error("nmi still pending after arbitration clear");
  timer0_clear_a: assert property (wrB && ioWrData[7] |=> timer0InterruptRequestClr)
    else $error("timer 0 latch clear missing");
  gate_follow_a: assert property (wrA |=> addressLineTwentyEn == $past(ioWrData[1]))
    else $error("address line twenty gate not written");
  lock_sticky_a: assert property (disable iff (powerOnRst) passwordLock |=> passwordLock)
    else $error("password lock dropped");
  pulse_one_a: assert property ($rose(cpuAltReset) |=> !cpuAltReset)
    else $error("alternate reset pulse too long");
  hot_window_a: assert property (cpuAltReset |-> sinceHot >= 8'h44 && sinceHot <= 8'h86)
    else $error("alternate reset outside its window");
  read_valid_a: assert property (1'b1 |=> ioRdValid == $past(rdOk))
    else $error("read valid wrong for address");
endmodule // scp_system_control_chk
bind scp_system_control scp_system_control_chk u_scp_system_control_chk (.*);
`default_nettype wire

// ==== scp_cpu_model.sv ====
// Purpose: processor side of the i/o port space
// Assumes: one-cycle strobes launched just after a rising edge
// Notes:   after wr or rd the buses they drove show the inverse of their last value; mask leaves its index write in place
`timescale 1ns/1ps
`default_nettype none
module scp_cpu_model (
  // clock
  input  wire logic        sys_clk,
  // i/o cycle
  output logic      [15:0] ioAddr,
  output logic      [7:0]  ioWrData,
  output logic             ioWr,
  output logic             ioRd,
  input  wire logic [7:0]  ioRdData,
  input  wire logic        ioRdValid,
  // mask lane of the real_time_memory index write
  output logic             nmiMaskWr,
  output logic             nmiMaskData
);
  initial begin
    ioAddr = 16'hFFFF;
    ioWrData = 8'h00;
    {ioWr, ioRd, nmiMaskWr, nmiMaskData} = 4'h1;
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    {ioAddr, ioWrData, ioWr} <= {a, d, 1'b1};
    @(posedge sys_clk);
    {ioAddr, ioWrData, ioWr} <= {~a, ~d, 1'b0};
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
    @(posedge sys_clk);
    {ioAddr, ioRd} <= {a, 1'b1};
    @(posedge sys_clk);
    {ioAddr, ioRd} <= {~a, 1'b0};
    #1;
    d = ioRdData;
    v = ioRdValid;
  endtask
  // index write carries the mask; the data port access must come next
  task automatic mask(input logic m, output logic [7:0] d, output logic v);
    @(posedge sys_clk);
    {ioAddr, ioWrData, ioWr} <= {16'h0070, m, 7'h0D, 1'b1};
    {nmiMaskWr, nmiMaskData} <= {1'b1, m};
    @(posedge sys_clk);
    {ioWr, nmiMaskWr} <= 2'h0;
    rd(16'h0071, d, v);
  endtask
endmodule // scp_cpu_model
`default_nettype wire

// ==== system_control_ports_nmi_tb.sv ====
// Purpose: self-checking bench for the system control ports and nmi
// Assumes: 10 MHz clock, both resets held 10 cycles at start
// Notes:   flags are cleared by disabling their checks before nmi release
`timescale 1ns/1ps
`default_nettype none
module system_control_ports_nmi_tb;
  logic sys_clk, rst, powerOnRst, ioWr, ioRd, ioRdValid, vld;
  logic [15:0] ioAddr;
  logic [7:0] ioWrData, ioRdData, rdv;
  logic [4:0] src;
  logic parityErr, channelCheck, channelTimeout, watchdogTimeout, refreshReq;
  logic watchdogStatus, nmiMaskWr, nmiMaskData, timer2Out, nmi, arbHalt;
  logic timer0InterruptRequestClr, speakerDataEn, timer2Gate, activityLight;
  logic passwordLock, addressLineTwentyEn, cpuAltReset;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc;
  assign {refreshReq, watchdogTimeout, channelTimeout, channelCheck, parityErr} = src;
  scp_system_control u_scp_system_control (.*);
  scp_cpu_model u_scp_cpu_model (.*);
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // ****************************************
  // tasks
  // ****************************************
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("comparisons=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    u_scp_cpu_model.wr(a, d);
    #1;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] exp);
    u_scp_cpu_model.rd(a, rdv, vld);
    chk(rdv, exp);
    chk({7'h00, vld}, 8'h01);
  endtask
  task pulse(input int i);
    @(posedge sys_clk);
    src[i] <= 1'b1;
    @(posedge sys_clk);
    src[i] <= 1'b0;
    #1;
  endtask
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    {rst, powerOnRst, src, watchdogStatus, timer2Out} = 9'h180;
    repeat (10) @(posedge sys_clk);
    {rst, powerOnRst, timer2Out} <= 3'h1;
    rd(16'h0061, 8'h2C);
    rd(16'h0092, 8'h00);
    wr(16'h0061, 8'hF3);
    chk({5'h00, timer0InterruptRequestClr, speakerDataEn, timer2Gate}, 8'h07);
    rd(16'h0061, 8'h23);
    pulse(4);
    rd(16'h0061, 8'h33);
    pulse(0);
    chk({7'h00, nmi}, 8'h00);
    rd(16'h0061, 8'hB3);
    wr(16'h0061, 8'h07);
    wr(16'h0061, 8'h03);
    rd(16'h0061, 8'h33);
    u_scp_cpu_model.mask(1'b0, rdv, vld);
    chk({7'h00, vld}, 8'h00);
    chk(rdv, 8'h00);
    pulse(1);
    chk({6'h00, nmi, arbHalt}, 8'h03);
    rd(16'h0061, 8'h73);
    wr(16'h0061, 8'h0B);
    chk({6'h00, nmi, arbHalt}, 8'h03);
    wr(16'h0090, 8'h00);
    chk({6'h00, nmi, arbHalt}, 8'h00);
    u_scp_cpu_model.mask(1'b1, rdv, vld);
    pulse(3);
    chk({7'h00, nmi}, 8'h01);
    wr(16'h0090, 8'h00);
    pulse(2);
    chk({7'h00, nmi}, 8'h01);
    watchdogStatus <= 1'b1;
    wr(16'h0092, 8'hFA);
    chk({5'h00, activityLight, passwordLock, addressLineTwentyEn}, 8'h07);
    rd(16'h0092, 8'hDA);
    watchdogStatus <= 1'b0;
    wr(16'h0092, 8'h40);
    rd(16'h0092, 8'h48);
    chk({7'h00, activityLight}, 8'h01);
    wr(16'h0092, 8'h02);
    chk({7'h00, activityLight}, 8'h00);
    wr(16'h0092, 8'h03);
    cyc = 0;
    while (cpuAltReset !== 1'b1 && cyc < 300) begin
      @(posedge sys_clk);
      #1 cyc++;
    end
    chk({7'h00, cyc >= scp_pkg::RST_DELAY_CYC && cyc <= scp_pkg::RST_TOTAL_CYC}, 8'h01);
    if (cyc >= 300) end_sim();
    @(posedge sys_clk);
    #1 chk({7'h00, cpuAltReset}, 8'h00);
    wr(16'h0092, 8'h0A);
    rd(16'h0092, 8'h0B);
    repeat (140) @(posedge sys_clk);
    wr(16'h0092, 8'h0A);
    rd(16'h0092, 8'h0A);
    wr(16'h0092, 8'h4B);
    pulse(3);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    #1 chk({6'h00, nmi, cpuAltReset}, 8'h00);
    rd(16'h0092, 8'h48);
    end_sim();
  end
endmodule // system_control_ports_nmi_tb
`default_nettype wire
